// File: src/tpps_pkg.sv
package tpps_pkg;

	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int TPPS_NMOD = 3;
	localparam int TPPS_CW = 12;

	// ************************************************************
	// Byte address map: address bit 0 selects the high byte
	// ************************************************************
	localparam int TPPS_HI_BIT = 0;
	localparam logic [3:0] TPPS_IDX_SA = 4'h0;
	localparam logic [3:0] TPPS_IDX_RA = 4'h3;
	localparam logic [3:0] TPPS_IDX_SB = 4'h6;
	localparam logic [3:0] TPPS_IDX_RB = 4'h9;
	localparam logic [3:0] TPPS_IDX_CNT = 4'ha;
	localparam logic [3:0] TPPS_IDX_OCFG = 4'hb;
	localparam logic [3:0] TPPS_IDX_OMAT = 4'hc;

	// Output bit fields: output A of module m at m, output B at m+3
	localparam int TPPS_FLD_A = 0;
	localparam int TPPS_FLD_B = 3;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [11:0] TPPS_CMP_RST = 12'h000;
	localparam logic [7:0] TPPS_BYTE_RST = 8'h00;
	localparam logic [5:0] TPPS_OUT_RST = 6'h00;

	// ************************************************************
	// Prescaler: terminal counts for divide by 1, 4, 32, 256
	// ************************************************************
	localparam logic [7:0] TPPS_DIV1_LIM = 8'h00;
	localparam logic [7:0] TPPS_DIV4_LIM = 8'h03;
	localparam logic [7:0] TPPS_DIV32_LIM = 8'h1f;
	localparam logic [7:0] TPPS_DIV256_LIM = 8'hff;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic {
		TPPS_ONE_RAMP = 1'b0,
		TPPS_CENTER = 1'b1
	} tpps_mode_e;

	typedef enum logic {
		TPPS_DOWN = 1'b0,
		TPPS_UP = 1'b1
	} tpps_ramp_e;

	// Register slot hit: index equals base plus module number
	function automatic logic tpps_hit(input logic [3:0] idx,
		input logic [3:0] base, input int m);
		tpps_hit = (idx == 4'(base + 4'(m)));
	endfunction

endpackage

// File: src/tpps_prescale.sv
`timescale 1ns/1ps
module tpps_prescale
	import tpps_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pll_tick,
	input wire logic io_tick,
	input wire logic clock_source_select,
	input wire logic [1:0] clock_prescale_field,
	output logic pwm_tick
);

	logic src_tick;
	logic [7:0] lim;
	logic [7:0] div_reg;

	// Source pick and terminal count
	always_comb begin
		src_tick = clock_source_select ? pll_tick : io_tick;
		case (clock_prescale_field)
			2'h0: lim = TPPS_DIV1_LIM;
			2'h1: lim = TPPS_DIV4_LIM;
			2'h2: lim = TPPS_DIV32_LIM;
			default: lim = TPPS_DIV256_LIM;
		endcase
	end

	// Divider; >= so a smaller ratio mid-count cannot run away
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= TPPS_BYTE_RST;
			pwm_tick <= 1'b0;
		end else begin
			pwm_tick <= 1'b0;
			if (src_tick) begin
				if (div_reg >= lim) begin
					div_reg <= TPPS_BYTE_RST;
					pwm_tick <= 1'b1;
				end else begin
					div_reg <= div_reg + 8'h01;
				end
			end
		end
	end

endmodule

// File: src/tpps_stage.sv
`timescale 1ns/1ps
// What this block does
// - One shared 8-bit high-byte staging register
// - Low-byte write loads staged high plus low
// - Low-byte read copies high byte into staging
// - 12-bit counter runs up to reset B
// - Three modules, each with outputs A and B
// - Cycle ends after sub-cycle B; changes follow
// - One mode setting drives all generators
// - Center mode counts down then up
// - One-ramp frequency is twice center frequency
// - One-ramp A: on reset-set, dead set+1
// - One-ramp B: on reset-set, dead setB-resetA
// - One-ramp overlap only without protection
// - Center mode on-times and dead time as given
// - Center cycle is twice reset B plus two
// - Center mode ignores reset A compare
// - Center mode aligns A on cycle center, B on cycle end
// - New value set applies together at cycle end
// - Halt, reload values, restart fresh cycle
// - Lock set blocks cycle-end transfer until released
// - Lock covers config, matrix, set A, B, reset B
// - Protection keeps A and B never both active
// - Clock from PLL or I/O, divided 1/4/32/256
// - Each module interrupts on counter reload
module tpps_stage
	import tpps_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pll_tick,
	input wire logic io_tick,
	input wire logic clock_source_select,
	input wire logic [1:0] clock_prescale_field,
	input wire logic run,
	input wire logic lock,
	input wire logic center_mode,
	input wire logic [2:0] overlap_enable_bit,
	input wire logic [4:0] cpu_addr,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [7:0] cpu_wdata,
	output logic [7:0] cpu_rdata,
	output logic [2:0] drive_output_a,
	output logic [2:0] drive_output_b,
	output logic [2:0] module_irq
);

	// ************************************************************
	// Declarations
	// ************************************************************
	logic [7:0] stage_reg;
	logic [2:0][11:0] sa_sh_reg;
	logic [2:0][11:0] sb_sh_reg;
	logic [2:0][11:0] ra_reg;
	logic [11:0] rb_sh_reg;
	logic [5:0] ocfg_sh_reg;
	logic [5:0] omat_sh_reg;
	logic [2:0][11:0] sa_act_reg;
	logic [2:0][11:0] sb_act_reg;
	logic [11:0] rb_act_reg;
	logic [5:0] ocfg_act_reg;
	logic [5:0] omat_act_reg;
	tpps_mode_e mode_act_reg;
	tpps_mode_e mode_next;
	tpps_ramp_e ramp_reg;
	logic [11:0] cnt_reg;
	logic [11:0] rb_next;
	logic [11:0] sel_word;
	logic [3:0] idx;
	logic hi;
	logic wr_lo;
	logic rd_lo;
	logic pwm_tick;
	logic at_top;
	logic cycle_end;
	logic load;
	wire logic [2:0] a_raw;
	wire logic [2:0] b_raw;
	wire logic [2:0] b_prot;

	// ************************************************************
	// Pwm clock
	// ************************************************************

	// Prescaled tick; all counting advances only on it
	tpps_prescale u_prescale (
		.clk(clk),
		.rst_n(rst_n),
		.pll_tick(pll_tick),
		.io_tick(io_tick),
		.clock_source_select(clock_source_select),
		.clock_prescale_field(clock_prescale_field),
		.pwm_tick(pwm_tick)
	);

	// ************************************************************
	// Byte access decode
	// ************************************************************
	assign idx = cpu_addr[4:1];
	assign hi = cpu_addr[TPPS_HI_BIT];
	assign wr_lo = cpu_wr & ~hi;
	assign rd_lo = cpu_rd & ~hi;

	// Word selected for a read; unmapped slots read zero
	always_comb begin
		sel_word = TPPS_CMP_RST;
		for (int m = 0; m < TPPS_NMOD; m++) begin
			if (tpps_hit(idx, TPPS_IDX_SA, m))
				sel_word = sa_sh_reg[m];
			if (tpps_hit(idx, TPPS_IDX_RA, m))
				sel_word = ra_reg[m];
			if (tpps_hit(idx, TPPS_IDX_SB, m))
				sel_word = sb_sh_reg[m];
		end
		if (idx == TPPS_IDX_RB)
			sel_word = rb_sh_reg;
		if (idx == TPPS_IDX_CNT)
			sel_word = cnt_reg;
		if (idx == TPPS_IDX_OCFG)
			sel_word = {6'h00, ocfg_sh_reg};
		if (idx == TPPS_IDX_OMAT)
			sel_word = {6'h00, omat_sh_reg};
	end

	// Shared staging byte; high write fills it, low read loads it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage_reg <= TPPS_BYTE_RST;
		end else if (cpu_wr && hi) begin
			stage_reg <= cpu_wdata;
		end else if (rd_lo) begin
			stage_reg <= {4'h0, sel_word[11:8]};
		end
	end

	// Read data: low byte live, high byte from staging
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_rdata <= TPPS_BYTE_RST;
		end else if (cpu_rd) begin
			cpu_rdata <= hi ? stage_reg : sel_word[7:0];
		end
	end

	// ************************************************************
	// Written values
	// ************************************************************

	// Low write commits staged high and written low in one cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sa_sh_reg <= '0;
			sb_sh_reg <= '0;
			ra_reg <= '0;
			rb_sh_reg <= TPPS_CMP_RST;
			ocfg_sh_reg <= TPPS_OUT_RST;
			omat_sh_reg <= TPPS_OUT_RST;
		end else if (wr_lo) begin
			for (int m = 0; m < TPPS_NMOD; m++) begin
				if (tpps_hit(idx, TPPS_IDX_SA, m))
					sa_sh_reg[m] <= {stage_reg[3:0], cpu_wdata};
				if (tpps_hit(idx, TPPS_IDX_RA, m))
					ra_reg[m] <= {stage_reg[3:0], cpu_wdata};
				if (tpps_hit(idx, TPPS_IDX_SB, m))
					sb_sh_reg[m] <= {stage_reg[3:0], cpu_wdata};
			end
			if (idx == TPPS_IDX_RB)
				rb_sh_reg <= {stage_reg[3:0], cpu_wdata};
			if (idx == TPPS_IDX_OCFG)
				ocfg_sh_reg <= cpu_wdata[5:0];
			if (idx == TPPS_IDX_OMAT)
				omat_sh_reg <= cpu_wdata[5:0];
		end
	end

	// ************************************************************
	// Cycle end and update
	// ************************************************************

	// Cycle closes at top of the last ramp, i.e. end of part B
	assign at_top = (cnt_reg >= rb_act_reg);
	assign cycle_end = run & pwm_tick & at_top &
		((mode_act_reg == TPPS_ONE_RAMP) | (ramp_reg == TPPS_UP));

	// Stopped: follow written values so a restart uses them at once
	assign load = ~run | (cycle_end & ~lock);

	assign mode_next = load ? tpps_mode_e'(center_mode) : mode_act_reg;
	assign rb_next = load ? rb_sh_reg : rb_act_reg;

	// Whole set moves together; reset A is not part of it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sa_act_reg <= '0;
			sb_act_reg <= '0;
			rb_act_reg <= TPPS_CMP_RST;
			ocfg_act_reg <= TPPS_OUT_RST;
			omat_act_reg <= TPPS_OUT_RST;
			mode_act_reg <= TPPS_ONE_RAMP;
		end else if (load) begin
			sa_act_reg <= sa_sh_reg;
			sb_act_reg <= sb_sh_reg;
			rb_act_reg <= rb_sh_reg;
			ocfg_act_reg <= ocfg_sh_reg;
			omat_act_reg <= omat_sh_reg;
			mode_act_reg <= mode_next;
		end
	end

	// ************************************************************
	// Counter
	// ************************************************************

	// Center mode holds 0 and top for one tick each so a cycle
	// is 2*(top+1); one-ramp is top+1, hence double frequency
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= TPPS_CMP_RST;
			ramp_reg <= TPPS_DOWN;
		end else if (!run) begin
			cnt_reg <= center_mode ? rb_sh_reg : TPPS_CMP_RST;
			ramp_reg <= TPPS_DOWN;
		end else if (cycle_end) begin
			cnt_reg <= (mode_next == TPPS_CENTER) ? rb_next : TPPS_CMP_RST;
			ramp_reg <= TPPS_DOWN;
		end else if (pwm_tick) begin
			case (mode_act_reg)
				TPPS_ONE_RAMP: begin
					cnt_reg <= cnt_reg + 12'h001;
				end
				TPPS_CENTER: begin
					case (ramp_reg)
						TPPS_DOWN: begin
							if (cnt_reg == TPPS_CMP_RST)
								ramp_reg <= TPPS_UP;
							else
								cnt_reg <= cnt_reg - 12'h001;
						end
						TPPS_UP: begin
							cnt_reg <= cnt_reg + 12'h001;
						end
						default: begin
							ramp_reg <= TPPS_DOWN;
						end
					endcase
				end
				default: begin
					cnt_reg <= TPPS_CMP_RST;
				end
			endcase
		end
	end

	// ************************************************************
	// Waveform generators
	// ************************************************************

	// One generator pair per module
	for (genvar m = 0; m < TPPS_NMOD; m++) begin : g_mod
		// One-ramp: A after set A up to reset A, B after set B to top
		// Center: A below set A, B from set B up; reset A unused
		assign a_raw[m] = (mode_act_reg == TPPS_CENTER) ?
			(cnt_reg < sa_act_reg[m]) :
			((cnt_reg > sa_act_reg[m]) && (cnt_reg <= ra_reg[m]));
		assign b_raw[m] = (mode_act_reg == TPPS_CENTER) ?
			(cnt_reg >= sb_act_reg[m]) :
			((cnt_reg > sb_act_reg[m]) && (cnt_reg <= rb_act_reg));
		// A wins; overlap only when the module's bit allows it
		assign b_prot[m] = b_raw[m] &
			~(a_raw[m] & ~overlap_enable_bit[m]);
	end

	// Outputs registered; idle and disabled outputs sit inactive
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			drive_output_a <= 3'h0;
			drive_output_b <= 3'h0;
		end else begin
			drive_output_a <= (a_raw & ocfg_act_reg[2:0] & {3{run}}) ^
				omat_act_reg[2:0];
			drive_output_b <= (b_prot & ocfg_act_reg[5:3] & {3{run}}) ^
				omat_act_reg[5:3];
		end
	end

	// Reload request, one pulse per module per cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			module_irq <= 3'h0;
		else
			module_irq <= {3{cycle_end}};
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_stage_read;
		(rd_lo && !cpu_wr) |=> stage_reg == {4'h0, $past(sel_word[11:8])};
	endproperty
	a_stage_read: assert property (p_stage_read)
		else $error("staging byte not loaded by low read");

	property p_word_write;
		(wr_lo && idx == TPPS_IDX_RB) |=>
			rb_sh_reg == {$past(stage_reg[3:0]), $past(cpu_wdata)};
	endproperty
	a_word_write: assert property (p_word_write)
		else $error("low write did not commit the word");

	property p_cnt_bound;
		run && $past(run) |-> cnt_reg <= rb_act_reg;
	endproperty
	a_cnt_bound: assert property (p_cnt_bound)
		else $error("counter above top");

	property p_wrap;
		(cycle_end && mode_next == TPPS_ONE_RAMP && run) |=>
			cnt_reg == TPPS_CMP_RST;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("one-ramp counter did not restart at zero");

	property p_bottom;
		(run && pwm_tick && mode_act_reg == TPPS_CENTER &&
			ramp_reg == TPPS_DOWN && cnt_reg == TPPS_CMP_RST) |=>
			(ramp_reg == TPPS_UP && cnt_reg == TPPS_CMP_RST) ||
			!$past(run);
	endproperty
	a_bottom: assert property (p_bottom)
		else $error("center ramp did not turn at bottom");

	property p_overlap;
		(!overlap_enable_bit[0] && omat_act_reg[0] == 1'b0 &&
			omat_act_reg[3] == 1'b0) |=>
			!(drive_output_a[0] && drive_output_b[0]);
	endproperty
	a_overlap: assert property (p_overlap)
		else $error("both outputs of module 0 active");

	property p_lock;
		(run && lock && !cycle_end) or (run && lock) |=>
			$stable(sb_act_reg) && $stable(rb_act_reg);
	endproperty
	a_lock: assert property (p_lock)
		else $error("values moved while locked");

	property p_update;
		(cycle_end && !lock) |=> sb_act_reg == $past(sb_sh_reg) &&
			rb_act_reg == $past(rb_sh_reg) &&
			sa_act_reg == $past(sa_sh_reg);
	endproperty
	a_update: assert property (p_update)
		else $error("set not applied at cycle end");

	property p_irq;
		1'b1 |=> module_irq == {3{$past(cycle_end)}};
	endproperty
	a_irq: assert property (p_irq)
		else $error("reload request not tied to cycle end");

	property p_idle;
		!run |=> drive_output_a == $past(omat_act_reg[2:0]) &&
			drive_output_b == $past(omat_act_reg[5:3]);
	endproperty
	a_idle: assert property (p_idle)
		else $error("output active while stopped");

	c_center_end: cover property (cycle_end &&
		mode_act_reg == TPPS_CENTER);
	c_ramp_end: cover property (cycle_end &&
		mode_act_reg == TPPS_ONE_RAMP);
	c_lock_hold: cover property (cycle_end && lock);
	c_overlap: cover property (a_raw[1] && b_raw[1]);

endmodule

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench
	import tpps_pkg::*;
;
	// ************************************************************
	// Signals
	// ************************************************************
	localparam int CYC_LIMIT = 20000;
	logic clk, rst_n, pll_tick, io_tick, clock_source_select;
	logic [1:0] clock_prescale_field;
	logic run, lock, center_mode;
	logic [2:0] overlap_enable_bit;
	logic [4:0] cpu_addr;
	logic cpu_wr, cpu_rd;
	logic [7:0] cpu_wdata, cpu_rdata;
	logic [2:0] drive_output_a, drive_output_b, module_irq;
	logic [15:0] shoot_cnt, shoot0;
	logic [11:0] word;
	int n_mismatch, check_count, cyc;
	int ca[3], cb[3], ci[3];
	int divs[4] = '{1, 4, 32, 256};

	tpps_stage dut (.clk(clk), .rst_n(rst_n), .pll_tick(pll_tick),
		.io_tick(io_tick), .clock_source_select(clock_source_select),
		.clock_prescale_field(clock_prescale_field), .run(run),
		.lock(lock), .center_mode(center_mode),
		.overlap_enable_bit(overlap_enable_bit), .cpu_addr(cpu_addr),
		.cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
		.cpu_rdata(cpu_rdata), .drive_output_a(drive_output_a),
		.drive_output_b(drive_output_b), .module_irq(module_irq));

	tpps_far_model far (.clk(clk), .rst_n(rst_n),
		.drive_output_a(drive_output_a), .drive_output_b(drive_output_b),
		.io_tick(io_tick), .pll_tick(pll_tick), .shoot_cnt(shoot_cnt));

	// ************************************************************
	// Clock and hang guard
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Runaway protection counted as a failure
	always @(posedge clk) begin
		cyc++;
		if (cyc == CYC_LIMIT) begin
			n_mismatch++;
			end_sim();
		end
	end

	// ************************************************************
	// Tasks
	// ************************************************************
	task end_sim;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen,
				exp);
		end
	endtask

	task wait_clk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// One byte cycle; read data is settled just after the taking edge
	task bus(input logic w, input logic [3:0] idx, input logic hi,
		input logic [7:0] d);
		wait_clk(1);
		cpu_wr = w;
		cpu_rd = !w;
		cpu_addr = {idx, hi};
		cpu_wdata = d;
		wait_clk(1);
		cpu_wr = 1'b0;
		cpu_rd = 1'b0;
	endtask

	task wr16(input logic [3:0] idx, input logic [11:0] v);
		bus(1'b1, idx, 1'b1, {4'h0, v[11:8]});
		bus(1'b1, idx, 1'b0, v[7:0]);
	endtask

	task rd16(input logic [3:0] idx, output logic [11:0] v);
		bus(1'b0, idx, 1'b0, 8'h00);
		v[7:0] = cpu_rdata;
		bus(1'b0, idx, 1'b1, 8'h00);
		v[11:8] = cpu_rdata[3:0];
	endtask

	// Same compares on every module; halted so they load at once
	task cfg(input logic [11:0] sa, input logic [11:0] ra,
		input logic [11:0] sb, input logic [11:0] rb);
		run = 1'b0;
		for (int m = 0; m < TPPS_NMOD; m++) begin
			wr16(TPPS_IDX_SA + 4'(m), sa);
			wr16(TPPS_IDX_RA + 4'(m), ra);
			wr16(TPPS_IDX_SB + 4'(m), sb);
		end
		wr16(TPPS_IDX_RB, rb);
	endtask

	task go(input logic cm);
		center_mode = cm;
		wait_clk(2);
		run = 1'b1;
		wait_clk(16);
	endtask

	// Window is a whole number of cycles, so phase does not matter
	task count_win(input int n);
		for (int m = 0; m < TPPS_NMOD; m++) begin
			ca[m] = 0;
			cb[m] = 0;
			ci[m] = 0;
		end
		repeat (n) begin
			wait_clk(1);
			for (int m = 0; m < TPPS_NMOD; m++) begin
				ca[m] += int'(drive_output_a[m] === 1'b1);
				cb[m] += int'(drive_output_b[m] === 1'b1);
				ci[m] += int'(module_irq[m] === 1'b1);
			end
		end
	endtask

	task expect3(input int ea, input int eb, input int ei);
		for (int m = 0; m < TPPS_NMOD; m++) begin
			chk(ca[m], ea);
			chk(cb[m], eb);
			chk(ci[m], ei);
		end
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		{rst_n, clock_source_select, clock_prescale_field} = 4'h0;
		{run, lock, center_mode, overlap_enable_bit} = 6'h00;
		{cpu_addr, cpu_wr, cpu_rd, cpu_wdata} = 15'h0000;
		{n_mismatch, check_count, cyc} = {32'h0, 32'h0, 32'h0};
		wait_clk(6);
		rst_n = 1'b1;
		chk({drive_output_a, drive_output_b, module_irq}, 32'h0);
		rd16(TPPS_IDX_RB, word);
		chk(word, 12'h000);
		$display("test reset done");

		wr16(TPPS_IDX_SA + 4'h1, 12'h123);
		rd16(TPPS_IDX_SA + 4'h1, word);
		chk(word, 12'h123);
		bus(1'b1, TPPS_IDX_RA, 1'b1, 8'h0a);
		bus(1'b1, TPPS_IDX_SB, 1'b0, 8'h55);
		rd16(TPPS_IDX_SB, word);
		chk(word, 12'ha55);
		bus(1'b0, TPPS_IDX_SA + 4'h1, 1'b0, 8'h00);
		chk(cpu_rdata, 8'h23);
		bus(1'b0, TPPS_IDX_RB, 1'b1, 8'h00);
		chk(cpu_rdata, 8'h01);
		bus(1'b0, 4'hd, 1'b0, 8'h00);
		chk(cpu_rdata, 8'h00);
		bus(1'b1, TPPS_IDX_CNT, 1'b0, 8'h77);
		bus(1'b0, TPPS_IDX_CNT, 1'b0, 8'h00);
		chk(cpu_rdata, 8'h00);
		bus(1'b1, TPPS_IDX_OMAT, 1'b0, 8'h3f);
		wait_clk(3);
		chk({drive_output_a, drive_output_b}, 6'h3f);
		bus(1'b1, TPPS_IDX_OMAT, 1'b0, 8'h00);
		$display("test access done");

		bus(1'b1, TPPS_IDX_OCFG, 1'b0, 8'h3f);
		cfg(12'h000, 12'h001, 12'h002, 12'h003);
		go(1'b0);
		count_win(40);
		expect3(10, 10, 10);
		$display("test one ramp done");

		cfg(12'h000, 12'h002, 12'h001, 12'h003);
		overlap_enable_bit = 3'b010;
		go(1'b0);
		shoot0 = shoot_cnt;
		count_win(40);
		chk(ca[1], 20);
		chk(cb[0], 10);
		chk(cb[1], 20);
		chk(cb[2], 10);
		chk(shoot_cnt - shoot0, 10);
		$display("test overlap done");

		overlap_enable_bit = 3'b000;
		cfg(12'h002, 12'h007, 12'h003, 12'h003);
		go(1'b1);
		count_win(40);
		expect3(20, 10, 5);
		for (int m = 0; m < TPPS_NMOD; m++) begin
			wr16(TPPS_IDX_RA + 4'(m), 12'h000);
		end
		wait_clk(8);
		count_win(40);
		expect3(20, 10, 5);
		$display("test center done");

		cfg(12'h000, 12'h001, 12'h002, 12'h003);
		go(1'b0);
		lock = 1'b1;
		for (int m = 0; m < TPPS_NMOD; m++) begin
			wr16(TPPS_IDX_SB + 4'(m), 12'h006);
		end
		wr16(TPPS_IDX_RB, 12'h007);
		// Config held too: A stays enabled until the lock is released
		bus(1'b1, TPPS_IDX_OCFG, 1'b0, 8'h38);
		count_win(40);
		expect3(10, 10, 10);
		lock = 1'b0;
		wait_clk(16);
		count_win(40);
		expect3(0, 5, 5);
		$display("test lock done");

		// Largest divide first so each smaller limit finds the count above it
		cfg(12'h000, 12'h001, 12'h002, 12'h003);
		go(1'b0);
		for (int s = 0; s < 2; s++) begin
			for (int p = 3; p >= 0; p--) begin
				clock_source_select = s[0];
				clock_prescale_field = p[1:0];
				wait_clk(4 * divs[p] * (s + 1));
				count_win(8 * divs[p] * (s + 1));
				chk(ci[0], 2);
			end
		end
		$display("test prescale done");
		end_sim();
	end
endmodule

// File: verif/tpps_far_model.sv
`timescale 1ns/1ps
module tpps_far_model
	import tpps_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] drive_output_a,
	input wire logic [2:0] drive_output_b,
	output logic io_tick,
	output logic pll_tick,
	output logic [15:0] shoot_cnt
);
	// ************************************************************
	// Clock sources and bridge monitor
	// ************************************************************
	logic half_reg;

	// I/O source ticks every clk, PLL source every other clk
	assign io_tick = 1'b1;
	assign pll_tick = half_reg;

	// Phase of the slower source
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			half_reg <= 1'b0;
		end else begin
			half_reg <= ~half_reg;
		end
	end

	// Cross conduction seen by the bridges, any module
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shoot_cnt <= 16'h0000;
		end else if ((drive_output_a & drive_output_b) != 3'h0) begin
			shoot_cnt <= shoot_cnt + 16'h0001;
		end
	end
endmodule
